// *** design/reload_timer_pkg.sv ***
// Operation
// - The count clock is the peripheral clock divided by two to the power of a 4-bit select, 0x0 to 0xe, with 0xf reserved and reset to 0x0.
// - A 16-bit read/write reload value, reset to zero, presets the counter.
// - The counter value reads back as 16 bits, resets to 0xffff and ignores writes.
// - Control bit D4 selects one-shot when one and repeat when zero, resetting to zero.
// - Writing one to the write-only timer reset bit presets the counter, and writing zero does nothing.
// - Control bit D0 runs the timer when one and stops it when zero, resetting to zero.
// - The interrupt request is passed on only while enable bit D8 is one, which resets to zero.
// - Flag bit D0 is set by the interrupt cause, cleared by writing one, unchanged by writing zero, and resets to zero.
// - A second channel has its own prescaler select register at 0x4240 with the same layout and reset.
package reload_timer_pkg;
  localparam logic [15:0] CH1_DIV_OFS = 16'h4220;
  localparam logic [15:0] CH1_RELOAD_OFS = 16'h4222;
  localparam logic [15:0] CH1_COUNT_OFS = 16'h4224;
  localparam logic [15:0] CH1_CTL_OFS = 16'h4226;
  localparam logic [15:0] CH1_INT_OFS = 16'h4228;
  localparam logic [15:0] CH2_DIV_OFS = 16'h4240;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam int RUN_BIT = 0;
  localparam int SRST_BIT = 1;
  localparam int MODE_BIT = 4;
  localparam int FLAG_BIT = 0;
  localparam int IEN_BIT = 8;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [3:0] SEL_RESERVED = 4'hF;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'hFFFF;
  localparam int DIV_W = 14;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic oneshot_mode;
    logic timer_run;
  } timer_ctl_t;

  typedef struct packed {
    logic timer_irq_enable;
    logic timer_irq_flag;
  } timer_irq_t;
endpackage : reload_timer_pkg

// *** design/reload_timer.sv ***
// The strobed register port was decided locally.
`timescale 1ns/1ps
module reload_timer #(
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire reload_timer_pkg::bus_req_t bus_req,
  output logic [15:0] rdata,
  output logic irq
);
  import reload_timer_pkg::*;

  if (DATA_W != 16) begin : g_width_check
    $error("reload_timer supports only 16-bit registers");
  end

  logic [SEL_W-1:0] prescale_select;
  logic [SEL_W-1:0] ch2_prescale_select;
  logic [15:0] reload_value;
  logic [15:0] counter_value;
  logic [DIV_W-1:0] prescale_cnt;
  timer_ctl_t ctl;
  timer_irq_t irqs;

  logic [SEL_W-1:0] next_prescale_select;
  logic [SEL_W-1:0] next_ch2_prescale_select;
  logic [15:0] next_reload_value;
  logic [15:0] next_counter_value;
  logic [DIV_W-1:0] next_prescale_cnt;
  timer_ctl_t next_ctl;
  timer_irq_t next_irqs;
  logic [15:0] next_rdata;
  logic next_irq;

  logic wr_ctl;
  logic wr_int;
  logic soft_reset;
  logic tick;
  logic underflow;

  // Last prescaler count for a select code
  function automatic logic [DIV_W-1:0] div_last(input logic [SEL_W-1:0] sel);
    logic [2**SEL_W-1:0] one_hot;
    one_hot = '0;
    one_hot[sel] = 1'b1;
    return DIV_W'(one_hot - 1'b1);
  endfunction : div_last

  assign wr_ctl = bus_req.wr && (bus_req.addr == CH1_CTL_OFS);
  assign wr_int = bus_req.wr && (bus_req.addr == CH1_INT_OFS);
  assign soft_reset = wr_ctl && bus_req.wdata[SRST_BIT];
  // Divided count clock, none on reserved code
  assign tick = (prescale_select != SEL_RESERVED)
      && (prescale_cnt >= div_last(prescale_select));
  assign underflow = ctl.timer_run && tick && !soft_reset && (counter_value == 16'h0000);

  always_comb begin
    next_prescale_select = prescale_select;
    next_ch2_prescale_select = ch2_prescale_select;
    next_reload_value = reload_value;
    next_counter_value = counter_value;
    next_prescale_cnt = prescale_cnt;
    next_ctl = ctl;
    next_irqs = irqs;
    next_rdata = 16'h0000;
    if (bus_req.wr) begin
      if (bus_req.addr == CH1_DIV_OFS) begin
        next_prescale_select = bus_req.wdata[SEL_LSB +: SEL_W];
      end else if (bus_req.addr == CH2_DIV_OFS) begin
        next_ch2_prescale_select = bus_req.wdata[SEL_LSB +: SEL_W];
      end else if (bus_req.addr == CH1_RELOAD_OFS) begin
        next_reload_value = bus_req.wdata;
      end else if (bus_req.addr == CH1_CTL_OFS) begin
        next_ctl.oneshot_mode = bus_req.wdata[MODE_BIT];
        next_ctl.timer_run = bus_req.wdata[RUN_BIT];
      end else if (bus_req.addr == CH1_INT_OFS) begin
        next_irqs.timer_irq_enable = bus_req.wdata[IEN_BIT];
      end
    end
    if (wr_int && bus_req.wdata[FLAG_BIT]) begin
      next_irqs.timer_irq_flag = 1'b0;
    end
    if (soft_reset) begin
      next_counter_value = reload_value;
      next_prescale_cnt = '0;
    end else if (!ctl.timer_run || tick) begin
      next_prescale_cnt = '0;
    end else begin
      next_prescale_cnt = prescale_cnt + 1'b1;
    end
    if (ctl.timer_run && tick && !soft_reset) begin
      if (underflow) begin
        next_counter_value = reload_value;
      end else begin
        next_counter_value = counter_value - 16'h0001;
      end
    end
    if (underflow) begin
      next_irqs.timer_irq_flag = 1'b1;
      if (ctl.oneshot_mode) begin
        next_ctl.timer_run = 1'b0;
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == CH1_DIV_OFS) begin
        next_rdata[SEL_LSB +: SEL_W] = prescale_select;
      end else if (bus_req.addr == CH2_DIV_OFS) begin
        next_rdata[SEL_LSB +: SEL_W] = ch2_prescale_select;
      end else if (bus_req.addr == CH1_RELOAD_OFS) begin
        next_rdata = reload_value;
      end else if (bus_req.addr == CH1_COUNT_OFS) begin
        next_rdata = counter_value;
      end else if (bus_req.addr == CH1_CTL_OFS) begin
        next_rdata[MODE_BIT] = ctl.oneshot_mode;
        next_rdata[RUN_BIT] = ctl.timer_run;
      end else if (bus_req.addr == CH1_INT_OFS) begin
        next_rdata[IEN_BIT] = irqs.timer_irq_enable;
        next_rdata[FLAG_BIT] = irqs.timer_irq_flag;
      end
    end
    next_irq = next_irqs.timer_irq_flag && next_irqs.timer_irq_enable;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescale_select <= SEL_RST;
      ch2_prescale_select <= SEL_RST;
      reload_value <= RELOAD_RST;
      counter_value <= COUNT_RST;
      prescale_cnt <= '0;
      ctl <= '0;
      irqs <= '0;
      rdata <= 16'h0000;
      irq <= 1'b0;
    end else begin
      prescale_select <= next_prescale_select;
      ch2_prescale_select <= next_ch2_prescale_select;
      reload_value <= next_reload_value;
      counter_value <= next_counter_value;
      prescale_cnt <= next_prescale_cnt;
      ctl <= next_ctl;
      irqs <= next_irqs;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  count_reset_a: assert property (
    $fell(rst) |-> counter_value == COUNT_RST && !ctl.timer_run && !irq)
    else $error("counter not at reset value");

  select_reset_a: assert property (
    $fell(rst) |-> prescale_select == SEL_RST && ch2_prescale_select == SEL_RST)
    else $error("select not at reset value");

  stopped_hold_a: assert property (
    !ctl.timer_run && !soft_reset |=> counter_value == $past(counter_value))
    else $error("counter moved while stopped");

  reserved_hold_a: assert property (
    prescale_select == SEL_RESERVED && !soft_reset
    |=> counter_value == $past(counter_value))
    else $error("counter moved on reserved select");

  divide_one_a: assert property (
    ctl.timer_run && prescale_select == 4'h0 && !soft_reset && counter_value != 16'h0000
    |=> counter_value == $past(counter_value) - 16'h0001)
    else $error("no decrement at divide by one");

  divide_two_a: assert property (
    ctl.timer_run && prescale_select == 4'h1 && prescale_cnt == '0 && !soft_reset
    && (counter_value != 16'h0000 || reload_value != 16'h0000)
    && !bus_req.wr ##1 !soft_reset && !bus_req.wr
    |=> counter_value != $past(counter_value, 2) || !$past(ctl.timer_run))
    else $error("divide by two missed a count");

  underflow_reload_a: assert property (
    underflow |=> counter_value == $past(reload_value) && irqs.timer_irq_flag)
    else $error("underflow did not reload and flag");

  oneshot_stop_a: assert property (
    underflow && ctl.oneshot_mode |=> !ctl.timer_run)
    else $error("one-shot did not stop");

  repeat_run_a: assert property (
    underflow && !ctl.oneshot_mode && !wr_ctl |=> ctl.timer_run)
    else $error("repeat mode stopped");

  soft_reset_a: assert property (
    soft_reset |=> counter_value == $past(reload_value) && prescale_cnt == '0)
    else $error("soft reset did not preset");

  flag_clear_a: assert property (
    wr_int && bus_req.wdata[FLAG_BIT] && !underflow |=> !irqs.timer_irq_flag)
    else $error("flag not cleared by write one");

  flag_keep_a: assert property (
    irqs.timer_irq_flag && !(wr_int && bus_req.wdata[FLAG_BIT]) |=> irqs.timer_irq_flag)
    else $error("flag lost without clear");

  irq_gate_a: assert property (
    irq == (irqs.timer_irq_flag && irqs.timer_irq_enable))
    else $error("irq disagrees with flag and enable");

  irq_enable_a: assert property (
    !irqs.timer_irq_enable |-> !irq)
    else $error("irq while disabled");

  ctl_read_a: assert property (
    bus_req.rd && bus_req.addr == CH1_CTL_OFS
    |=> rdata[15:5] == '0 && rdata[SRST_BIT] == 1'b0 && rdata[RUN_BIT] == $past(ctl.timer_run))
    else $error("control readback wrong");

  count_read_a: assert property (
    bus_req.rd && bus_req.addr == CH1_COUNT_OFS |=> rdata == $past(counter_value))
    else $error("counter readback wrong");

  rdata_idle_a: assert property (
    !bus_req.rd |=> rdata == 16'h0000)
    else $error("read data not zero when idle");

  reload_write_a: assert property (
    bus_req.wr && bus_req.addr == CH1_RELOAD_OFS
    |=> reload_value == $past(bus_req.wdata))
    else $error("reload value not written");

  reload_read_a: assert property (
    bus_req.rd && bus_req.addr == CH1_RELOAD_OFS
    |=> rdata == $past(reload_value))
    else $error("reload readback wrong");

  count_nowrite_a: assert property (
    bus_req.wr && bus_req.addr == CH1_COUNT_OFS && !ctl.timer_run
    |=> counter_value == $past(counter_value))
    else $error("counter changed by a write");

  select_write_a: assert property (
    bus_req.wr && bus_req.addr == CH1_DIV_OFS
    |=> prescale_select == $past(bus_req.wdata[SEL_LSB +: SEL_W]))
    else $error("select not written");

  ch2_select_a: assert property (
    bus_req.wr && bus_req.addr == CH2_DIV_OFS
    |=> ch2_prescale_select == $past(bus_req.wdata[SEL_LSB +: SEL_W]))
    else $error("second select not written");

  select_read_a: assert property (
    bus_req.rd && (bus_req.addr == CH1_DIV_OFS || bus_req.addr == CH2_DIV_OFS)
    |=> rdata[15:4] == '0)
    else $error("select readback reserved bits set");

  int_read_a: assert property (
    bus_req.rd && bus_req.addr == CH1_INT_OFS
    |=> rdata[15:9] == '0 && rdata[7:1] == '0
    && rdata[FLAG_BIT] == $past(irqs.timer_irq_flag))
    else $error("interrupt readback wrong");

  enable_write_a: assert property (
    wr_int |=> irqs.timer_irq_enable == $past(bus_req.wdata[IEN_BIT]))
    else $error("enable not written");

  run_write_a: assert property (
    wr_ctl && !underflow |=> ctl.timer_run == $past(bus_req.wdata[RUN_BIT]))
    else $error("run bit not written");

  mode_write_a: assert property (
    wr_ctl |=> ctl.oneshot_mode == $past(bus_req.wdata[MODE_BIT]))
    else $error("mode bit not written");

  prescale_wrap_a: assert property (
    ctl.timer_run && tick && !soft_reset |=> prescale_cnt == '0)
    else $error("prescaler did not restart on tick");

  prescale_step_a: assert property (
    ctl.timer_run && !tick && !soft_reset
    |=> prescale_cnt == $past(prescale_cnt) + DIV_W'(1))
    else $error("prescaler did not advance");

  stopped_prescale_a: assert property (
    !ctl.timer_run |=> prescale_cnt == '0)
    else $error("prescaler ran while stopped");

  irq_clear_a: assert property (
    wr_int && bus_req.wdata[FLAG_BIT] && !underflow |=> !irq)
    else $error("irq stayed after flag clear");

  repeat_underflow_c: cover property (underflow && !ctl.oneshot_mode);
  oneshot_stop_c: cover property (underflow && ctl.oneshot_mode ##1 !ctl.timer_run);
  irq_rise_c: cover property ($rose(irq));
  flag_clear_c: cover property (irqs.timer_irq_flag ##1 !irqs.timer_irq_flag);
  soft_start_c: cover property (soft_reset && bus_req.wdata[RUN_BIT]);
endmodule : reload_timer

// *** tb/test_sixteen_bit_reload_timer.sv ***
`timescale 1ns/1ps
module test_sixteen_bit_reload_timer;
  import reload_timer_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] r;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  bus_req_t bus_req = '0;
  logic [15:0] rdata;
  logic irq;
  logic irq_q = 1'b0;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int rises[$];
  logic [15:0] v;
  logic [15:0] w;
  row_t rows [7] = '{
    '{CH1_DIV_OFS, 16'h0000, 16'hFFFF, 16'h000F},
    '{CH2_DIV_OFS, 16'h0000, 16'hFFFE, 16'h000E},
    '{CH1_RELOAD_OFS, 16'h0000, 16'hA5C3, 16'hA5C3},
    '{CH1_COUNT_OFS, 16'hFFFF, 16'h1234, 16'hFFFF},
    '{CH1_CTL_OFS, 16'h0000, 16'h0012, 16'h0010},
    '{CH1_INT_OFS, 16'h0000, 16'hFFFE, 16'h0100},
    '{16'h422A, 16'h0000, 16'hFFFF, 16'h0000}
  };

  reload_timer dut (
    .core_clk(core_clk),
    .rst(rst),
    .bus_req(bus_req),
    .rdata(rdata),
    .irq(irq)
  );

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // Interrupt rise times
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    irq_q <= irq;
    if (irq === 1'b1 && irq_q === 1'b0) rises.push_back(cyc);
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_rise(input int n);
    for (int k = 0; k < 5000 && rises.size() < n; k++) @(posedge core_clk);
    if (rises.size() < n) begin
      error_cnt++;
      $display("[FAIL] %0t no interrupt", $time);
      complete_run();
    end
  endtask : wait_rise

  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (19) @(posedge core_clk);
    #1 chk(rdata, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge core_clk);
    rst <= 1'b0;
    // Reset value, write, read back
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      chk(v, rows[i].r);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
      $display("register row %0d done", i);
    end
    // One-shot underflow
    wr(CH1_DIV_OFS, 16'h0000);
    wr(CH1_RELOAD_OFS, 16'h0002);
    wr(CH1_CTL_OFS, 16'h0012);
    rd(CH1_COUNT_OFS, v);
    chk(v, 16'h0002);
    rises.delete();
    wr(CH1_CTL_OFS, 16'h0011);
    wait_rise(1);
    repeat (20) @(posedge core_clk);
    rd(CH1_CTL_OFS, v);
    chk(v, 16'h0010);
    rd(CH1_COUNT_OFS, v);
    chk(v, 16'h0002);
    rd(CH1_INT_OFS, v);
    chk(v, 16'h0101);
    // Flag and enable
    wr(CH1_INT_OFS, 16'h0100);
    @(posedge core_clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    wr(CH1_INT_OFS, 16'h0000);
    @(posedge core_clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    rd(CH1_INT_OFS, v);
    chk(v, 16'h0001);
    wr(CH1_INT_OFS, 16'h0001);
    rd(CH1_INT_OFS, v);
    chk(v, 16'h0000);
    $display("one-shot test done");
    // Repeat period for prescaler codes 0 to 3
    for (int s = 0; s < 4; s++) begin
      wr(CH1_CTL_OFS, 16'h0000);
      wr(CH1_INT_OFS, 16'h0101);
      wr(CH1_DIV_OFS, 16'(s));
      wr(CH1_RELOAD_OFS, 16'h0007);
      rises.delete();
      wr(CH1_CTL_OFS, 16'h0003);
      wait_rise(1);
      wr(CH1_INT_OFS, 16'h0101);
      wait_rise(2);
      wr(CH1_INT_OFS, 16'h0101);
      chk(16'(rises[1] - rises[0]), 16'(8 << s));
      $display("period test code %0d done", s);
    end
    // Reserved code and stop hold the counter
    wr(CH1_DIV_OFS, 16'h000F);
    rd(CH1_COUNT_OFS, v);
    repeat (40) @(posedge core_clk);
    rd(CH1_COUNT_OFS, w);
    chk(w, v);
    wr(CH1_DIV_OFS, 16'h0000);
    wr(CH1_CTL_OFS, 16'h0000);
    rd(CH1_COUNT_OFS, v);
    repeat (40) @(posedge core_clk);
    rd(CH1_COUNT_OFS, w);
    chk(w, v);
    rd(CH1_CTL_OFS, v);
    chk(v, 16'h0000);
    $display("hold test done");
    // Slowest code, one count per 16384 cycles
    wr(CH1_DIV_OFS, 16'h000E);
    wr(CH1_RELOAD_OFS, 16'h0001);
    wr(CH1_CTL_OFS, 16'h0003);
    repeat (16000) @(posedge core_clk);
    rd(CH1_COUNT_OFS, v);
    chk(v, 16'h0001);
    repeat (400) @(posedge core_clk);
    rd(CH1_COUNT_OFS, v);
    chk(v, 16'h0000);
    $display("slow code test done");
    // Reset in mid-run with the interrupt up
    wr(CH1_DIV_OFS, 16'h0000);
    wr(CH1_RELOAD_OFS, 16'h0003);
    wr(CH1_INT_OFS, 16'h0101);
    wr(CH1_CTL_OFS, 16'h0003);
    repeat (10) @(posedge core_clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk({15'h0000, irq}, 16'h0000);
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      chk(v, rows[i].r);
    end
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : test_sixteen_bit_reload_timer
